// *** iodec_defines.svh ***
`ifndef IODEC_DEFINES_SVH
`define IODEC_DEFINES_SVH

// ****************************************
// Fixed legacy I/O locations
// ****************************************
`define IODEC_INTC_LO_BLK   8'h01
`define IODEC_INTC_HI_BLK   8'h05
`define IODEC_INTC_ELCR     16'h04D0
`define IODEC_SIO_A         16'h002E
`define IODEC_SIO_B         16'h004E
`define IODEC_TMR_A         16'h0040
`define IODEC_TMR_B         16'h0050
`define IODEC_KBD_DATA      16'h0060
`define IODEC_NMI_PORT      16'h0061
`define IODEC_MC_A          16'h0062
`define IODEC_KBD_CMD       16'h0064
`define IODEC_MC_B          16'h0066
`define IODEC_RTC_BLK       16'h0070
`define IODEC_POST_BLK      8'h08
`define IODEC_POST_ALIAS    8'h09
`define IODEC_FAST_RST      16'h0092
`define IODEC_PM_CTL        16'h00B2
`define IODEC_RST_CTL       16'h0CF9
`define IODEC_GAME_BLK      16'h0200

// ****************************************
// Decode latency, legacy window size and read fill value
// ****************************************
`define IODEC_LATENCY       1
`define IODEC_WIN_BYTES     8
`define IODEC_ALL_ONES      32'hFFFFFFFF

`endif

// *** iodec_pkg.sv ***
package iodec_pkg;

   // ****************************************
   // Targets of a decoded cycle
   // ****************************************
   typedef enum logic [3:0] {
      IODEC_TGT_TERMINATE = 4'h0,
      IODEC_TGT_RESERVED  = 4'h1,
      IODEC_TGT_INTC      = 4'h2,
      IODEC_TGT_TIMER     = 4'h3,
      IODEC_TGT_NMI       = 4'h4,
      IODEC_TGT_RTC       = 4'h5,
      IODEC_TGT_RESET     = 4'h6,
      IODEC_TGT_PM        = 4'h7,
      IODEC_TGT_LPC       = 4'h8,
      IODEC_TGT_PCIE_SIDE = 4'h9,
      IODEC_TGT_ROOT_PORT = 4'hA,
      IODEC_TGT_SMB       = 4'hB
   } iodec_target_e;

   // ****************************************
   // Cycle from the host link
   // ****************************************
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
   } iodec_cycle_s;

   // ****************************************
   // Decision handed to the targets
   // ****************************************
   typedef struct packed {
      logic          valid;
      logic          write;
      logic [15:0]   addr;
      iodec_target_e target;
      logic [3:0]    port_idx;
      logic          rd_all_ones;
   } iodec_route_s;

   // ****************************************
   // Configuration bits from owning functions
   // ****************************************
   typedef struct packed {
      logic        nmi_port_alias_enable;
      logic        post_to_pcie;
      logic        sio_a_en;
      logic        sio_b_en;
      logic        kbd_en;
      logic        mc_en;
      logic        rtc_upper_en;
      logic        game_lo_en;
      logic        game_hi_en;
      logic [1:0]  serial_en;
      logic [5:0]  serial_sel;
      logic        par_en;
      logic [1:0]  par_sel;
      logic        fdc_en;
      logic        fdc_sel;
      logic        acpi_en;
      logic [15:0] acpi_base;
      logic        smb_en;
      logic [15:0] smb_base;
      logic        tco_en;
      logic [15:0] tco_base;
      logic [3:0]  gen_en;
      logic [63:0] gen_base;
      logic [31:0] gen_mask;
   } iodec_cfg_s;

   typedef logic [15:0] iodec_addr_t;

endpackage

// *** iodec_decoder.sv ***
`timescale 1ns/10ps
`include "iodec_defines.svh"
module iodec_decoder #(
   parameter int NUM_RP = 12,
   parameter logic [127:0] SER_BASES = {16'h02E8, 16'h02F8, 16'h03E8, 16'h03F8,
                                        16'h0338, 16'h0238, 16'h0220, 16'h0228},
   parameter logic [47:0]  PAR_BASES = {16'h0378, 16'h0278, 16'h03BC},
   parameter logic [31:0]  FDC_BASES = {16'h03F0, 16'h0370}
) (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   // Cycle from host link
   input  wire iodec_pkg::iodec_cycle_s cyc_in,
   // Configuration from owning functions
   input  wire iodec_pkg::iodec_cfg_s   cfg,
   input  wire logic [NUM_RP-1:0]    rp_en,
   input  wire logic [16*NUM_RP-1:0] rp_base,
   input  wire logic [16*NUM_RP-1:0] rp_limit,
   // Routed cycle
   output iodec_pkg::iodec_route_s   route_q
);
   import iodec_pkg::*;

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (NUM_RP < 1 || NUM_RP > 15) begin : g_chk
      $error("NUM_RP must lie between 1 and 15");
   end

   // ****************************************
   // Per-entry window matches
   // ****************************************
   logic [NUM_RP-1:0] rp_hit;
   logic [7:0]        ser_hit0;
   logic [7:0]        ser_hit1;
   logic [2:0]        par_hit;
   logic [1:0]        fdc_hit;
   logic [3:0]        gen_hit;
   iodec_addr_t       a;

   assign a = cyc_in.addr;

   // Root port base/limit windows, inclusive both ends
   for (genvar i = 0; i < NUM_RP; i++) begin : g_rp
      assign rp_hit[i] = rp_en[i] && a >= rp_base[16*i +: 16]
                         && a <= rp_limit[16*i +: 16];
   end
   // Legacy windows: 8 bytes from the selected base, which need not be aligned
   for (genvar s = 0; s < 8; s++) begin : g_ser
      assign ser_hit0[s] = cfg.serial_en[0] && cfg.serial_sel[2:0] == 3'(s)
                           && a >= SER_BASES[16*s +: 16]
                           && (a - SER_BASES[16*s +: 16]) < 16'(`IODEC_WIN_BYTES);
      assign ser_hit1[s] = cfg.serial_en[1] && cfg.serial_sel[5:3] == 3'(s)
                           && a >= SER_BASES[16*s +: 16]
                           && (a - SER_BASES[16*s +: 16]) < 16'(`IODEC_WIN_BYTES);
   end
   for (genvar p = 0; p < 3; p++) begin : g_par
      assign par_hit[p] = cfg.par_en && cfg.par_sel == 2'(p)
                          && a >= PAR_BASES[16*p +: 16]
                          && (a - PAR_BASES[16*p +: 16]) < 16'(`IODEC_WIN_BYTES);
   end
   for (genvar f = 0; f < 2; f++) begin : g_fdc
      assign fdc_hit[f] = cfg.fdc_en && cfg.fdc_sel == 1'(f)
                          && a >= FDC_BASES[16*f +: 16]
                          && (a - FDC_BASES[16*f +: 16]) < 16'(`IODEC_WIN_BYTES);
   end
   // Generic LPC windows, mask bits widen the window up to 256 bytes
   for (genvar g = 0; g < 4; g++) begin : g_gen
      assign gen_hit[g] = cfg.gen_en[g]
                          && ((a ^ cfg.gen_base[16*g +: 16])
                              & ~{8'h00, cfg.gen_mask[8*g +: 8]}) == 16'h0000;
   end

   // ****************************************
   // Priority decode, fixed ranges first
   // ****************************************
   // No overlap check: a fixed hit simply shadows a variable one.
   iodec_route_s route_d;
   iodec_target_e tgt;
   logic [3:0]    pidx;
   logic          lo_page;

   always_comb begin
      tgt     = IODEC_TGT_TERMINATE;
      pidx    = 4'h0;
      lo_page = a[15:8] == 8'h00;
      // Bytes with a[1] set (2-3 of every four) are never interrupt registers, so B2h-B3h fall through
      if (lo_page && (a[7:5] == 3'(`IODEC_INTC_LO_BLK) || a[7:5] == 3'(`IODEC_INTC_HI_BLK))
          && a[1] == 1'b0) begin
         tgt = IODEC_TGT_INTC;
      end else if (a[15:1] == 15'(`IODEC_INTC_ELCR >> 1)) begin
         tgt = IODEC_TGT_INTC;
      end else if ((a[15:1] == 15'(`IODEC_SIO_A >> 1) && cfg.sio_a_en)
                   || (a[15:1] == 15'(`IODEC_SIO_B >> 1) && cfg.sio_b_en)) begin
         tgt = IODEC_TGT_LPC;
      end else if (a == `IODEC_TMR_A || a == `IODEC_TMR_B
                   || a[15:1] == 15'(`IODEC_TMR_A >> 1) + 15'h0001
                   || a[15:1] == 15'(`IODEC_TMR_B >> 1) + 15'h0001) begin
         tgt = IODEC_TGT_TIMER;
      end else if ((a == `IODEC_KBD_DATA || a == `IODEC_KBD_CMD) && cfg.kbd_en) begin
         tgt = IODEC_TGT_LPC;
      end else if ((a == `IODEC_MC_A || a == `IODEC_MC_B) && cfg.mc_en) begin
         tgt = IODEC_TGT_LPC;
      end else if (a == `IODEC_NMI_PORT) begin
         tgt = IODEC_TGT_NMI;
      end else if (a[15:3] == 13'(`IODEC_NMI_PORT >> 3) && a[0] && a[2:1] != 2'b00) begin
         tgt = cfg.nmi_port_alias_enable ? IODEC_TGT_NMI : IODEC_TGT_PCIE_SIDE;
      end else if (a[15:3] == 13'(`IODEC_RTC_BLK >> 3) && (!a[1] || cfg.rtc_upper_en)) begin
         tgt = IODEC_TGT_RTC;
      end else if (lo_page && a[7:4] == 4'(`IODEC_POST_BLK) && a[1:0] != 2'b11
                   && (a[2] ? 1'b1 : a[1:0] == 2'b00)) begin
         // Reads of the write-only POST mirrors are reserved
         if (!cyc_in.write && a[3:0] != 4'h0) begin
            tgt = IODEC_TGT_RESERVED;
         end else begin
            tgt = cfg.post_to_pcie ? IODEC_TGT_PCIE_SIDE : IODEC_TGT_LPC;
         end
      end else if (a == `IODEC_FAST_RST || a == `IODEC_RST_CTL) begin
         tgt = IODEC_TGT_RESET;
      end else if (lo_page && a[7:4] == 4'(`IODEC_POST_ALIAS) && a[1:0] != 2'b11
                   && (a[2] ? 1'b1 : a[1:0] == 2'b00)) begin
         tgt = IODEC_TGT_LPC;
      end else if (a[15:1] == 15'(`IODEC_PM_CTL >> 1)) begin
         tgt = IODEC_TGT_PM;
      end else if (a[15:4] == 12'(`IODEC_GAME_BLK >> 4)
                   && (a[3] ? cfg.game_hi_en : cfg.game_lo_en)) begin
         tgt = IODEC_TGT_LPC;
      end else if (|{ser_hit0, ser_hit1, par_hit, fdc_hit, gen_hit}) begin
         tgt = IODEC_TGT_LPC;
      end else if (cfg.acpi_en && a >= cfg.acpi_base && a < cfg.acpi_base + 16'd96) begin
         tgt = IODEC_TGT_PM;
      end else if ((cfg.smb_en && a[15:5] == cfg.smb_base[15:5])
                   || (cfg.tco_en && a[15:5] == cfg.tco_base[15:5])) begin
         tgt = IODEC_TGT_SMB;
      end else if (|rp_hit) begin
         tgt = IODEC_TGT_ROOT_PORT;
         for (int k = NUM_RP - 1; k >= 0; k--) begin
            if (rp_hit[k]) begin
               pidx = 4'(k);
            end
         end
      end
      route_d             = '0;
      route_d.valid       = cyc_in.valid;
      route_d.write       = cyc_in.write;
      route_d.addr        = a;
      route_d.target      = cyc_in.valid ? tgt : IODEC_TGT_TERMINATE;
      route_d.port_idx    = pidx;
      route_d.rd_all_ones = cyc_in.valid && !cyc_in.write
                            && (tgt == IODEC_TGT_RESERVED || tgt == IODEC_TGT_TERMINATE);
   end

   // ****************************************
   // Output register, fixed one-cycle latency
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         route_q <= '0;
      end else begin
         route_q <= route_d;
      end
   end

   // Hit vector one cycle back, read only by the root-port check
   logic [NUM_RP-1:0] rp_hit_q;
   always_ff @(posedge clk_sys) begin
      rp_hit_q <= rp_hit;
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_nmi_alias;
      @(posedge clk_sys) disable iff (reset)
      cyc_in.valid && cyc_in.addr == 16'h0063 && cfg.nmi_port_alias_enable
      |=> route_q.target == IODEC_TGT_NMI;
   endproperty
   a_nmi_alias: assert property (p_nmi_alias) else $error("alias not sent to NMI");

   property p_nmi_alias_off;
      @(posedge clk_sys) disable iff (reset)
      cyc_in.valid && cyc_in.addr == 16'h0067 && !cfg.nmi_port_alias_enable
      |=> route_q.target == IODEC_TGT_PCIE_SIDE;
   endproperty
   a_nmi_alias_off: assert property (p_nmi_alias_off) else $error("alias not forwarded");

   property p_one_cycle;
      @(posedge clk_sys) disable iff (reset)
      cyc_in.valid |=> route_q.valid && route_q.addr == $past(cyc_in.addr);
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("routing latency wrong");

   property p_no_spurious;
      @(posedge clk_sys) disable iff (reset)
      !cyc_in.valid |=> !route_q.valid && route_q.target == IODEC_TGT_TERMINATE;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("output without cycle");

   property p_reserved_read;
      @(posedge clk_sys) disable iff (reset)
      cyc_in.valid && !cyc_in.write && cyc_in.addr == 16'h0088
      |=> route_q.target == IODEC_TGT_RESERVED && route_q.rd_all_ones;
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reserved read wrong");

   property p_ones_write;
      @(posedge clk_sys) disable iff (reset)
      route_q.rd_all_ones |-> route_q.valid && !route_q.write;
   endproperty
   a_ones_write: assert property (p_ones_write) else $error("all ones on a write");

   property p_serial_sel;
      @(posedge clk_sys) disable iff (reset)
      cyc_in.valid && |ser_hit0 |=> route_q.target == IODEC_TGT_LPC;
   endproperty
   a_serial_sel: assert property (p_serial_sel) else $error("serial window missed");

   property p_rootport;
      @(posedge clk_sys) disable iff (reset)
      route_q.target == IODEC_TGT_ROOT_PORT
      |-> route_q.valid && 32'(route_q.port_idx) < NUM_RP && rp_hit_q[route_q.port_idx];
   endproperty
   a_rootport: assert property (p_rootport) else $error("root port mismatch");

   property p_terminate;
      @(posedge clk_sys) disable iff (reset)
      cyc_in.valid && cyc_in.addr == 16'hFFFF && !(|rp_hit) && !(|gen_hit)
      && !(cfg.smb_en || cfg.tco_en || cfg.acpi_en)
      |=> route_q.target == IODEC_TGT_TERMINATE;
   endproperty
   a_terminate: assert property (p_terminate) else $error("unmatched cycle decoded");

endmodule // iodec_decoder

// *** iodec_host_model.sv ***
`timescale 1ns/10ps
// ****************************************
// Host link model issuing I/O cycles
// ****************************************
module iodec_host_model (
   // Clock
   input  wire logic               clk_sys,
   // Cycle toward the decoder
   output iodec_pkg::iodec_cycle_s cyc
);
   import iodec_pkg::*;

   // Link idle at time zero
   initial cyc = '0;

   // One call is one link cycle, launched on a rising edge
   task automatic drive(input logic v, input logic w, input logic [15:0] a);
      @(posedge clk_sys);
      if (v) begin
         cyc <= '{valid: v, write: w, addr: a};
      end else begin
         // Released lines invert, so a stale address never passes for a live one
         cyc <= '{valid: v, write: ~cyc.write, addr: ~cyc.addr};
      end
   endtask
endmodule // iodec_host_model

// *** test_io_space_address_decoder.sv ***
`timescale 1ns/10ps
// ****************************************
// Self-checking bench for the I/O decoder
// ****************************************
module test_io_space_address_decoder;
   import iodec_pkg::*;
   localparam logic [127:0] SER = {16'h0228, 16'h02E0, 16'h0238, 16'h0338,
                                   16'h02E8, 16'h03E8, 16'h02F8, 16'h03F8};
   localparam logic [47:0]  PAR = {16'h0378, 16'h0278, 16'h03BC};
   localparam logic [31:0]  FDC = {16'h03F0, 16'h0370};
   logic          clk_sys;
   logic          reset;
   iodec_cycle_s  cyc_in;
   iodec_cfg_s    cfg;
   iodec_cfg_s    nc;
   logic [11:0]   rp_en;
   logic [191:0]  rp_base;
   logic [191:0]  rp_limit;
   iodec_route_s  route_q;
   int            fail_count = 0;
   int            checked = 0;
   int            cycles = 0;

   iodec_decoder #(.NUM_RP(12), .SER_BASES(SER), .PAR_BASES(PAR), .FDC_BASES(FDC)) DUT (
      .clk_sys(clk_sys), .reset(reset), .cyc_in(cyc_in), .cfg(cfg), .rp_en(rp_en),
      .rp_base(rp_base), .rp_limit(rp_limit), .route_q(route_q));
   iodec_host_model host (.clk_sys(clk_sys), .cyc(cyc_in));

   // Clock and hang guard; a short run keeps the ceiling low
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         complete_run();
      end
   end

   // ****************************************
   // Shared checking tasks
   // ****************************************
   task automatic complete_run;
      if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         fail_count++;
      end
   endtask
   task automatic setcfg(input iodec_cfg_s c);
      @(posedge clk_sys);
      cfg <= c;
   endtask
   // Result is read just after the edge that registered it
   task automatic look(input logic w, input logic [15:0] a, input iodec_target_e t,
                       input logic [3:0] i, input logic o);
      #1;
      chk("valid", 32'h1, route_q.valid);
      chk("write", w, route_q.write);
      chk("addr", a, route_q.addr);
      chk("target", t, route_q.target);
      chk("rd_all_ones", o, route_q.rd_all_ones);
      if (t == IODEC_TGT_ROOT_PORT) chk("port_idx", i, route_q.port_idx);
   endtask
   task automatic hit(input logic w, input logic [15:0] a, input iodec_target_e t,
                      input logic [3:0] i, input logic o);
      host.drive(1'h1, w, a);
      host.drive(1'h0, 1'h0, 16'h0000);
      look(w, a, t, i, o);
   endtask
   // First and last byte hit, the byte past the end falls through
   task automatic win(input logic [15:0] b);
      hit(1'h0, b, IODEC_TGT_LPC, 4'h0, 1'h0);
      hit(1'h1, b + 16'h0007, IODEC_TGT_LPC, 4'h0, 1'h0);
      hit(1'h0, b + 16'h0008, IODEC_TGT_TERMINATE, 4'h0, 1'h1);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_nmi;
      nc = '0;
      nc.nmi_port_alias_enable = 1'h1;
      setcfg(nc);
      hit(1'h0, 16'h0063, IODEC_TGT_NMI, 4'h0, 1'h0);
      hit(1'h1, 16'h0067, IODEC_TGT_NMI, 4'h0, 1'h0);
      hit(1'h0, 16'hF061, IODEC_TGT_TERMINATE, 4'h0, 1'h1);
      nc.nmi_port_alias_enable = 1'h0;
      setcfg(nc);
      hit(1'h0, 16'h0065, IODEC_TGT_PCIE_SIDE, 4'h0, 1'h0);
      hit(1'h1, 16'h0061, IODEC_TGT_NMI, 4'h0, 1'h0);
      hit(1'h0, 16'h0067, IODEC_TGT_PCIE_SIDE, 4'h0, 1'h0);
   endtask
   task automatic t_windows;
      int p;
      int s;
      for (p = 0; p < 2; p++) begin
         for (s = 0; s < 8; s++) begin
            nc = '0;
            nc.serial_en = 2'h1 << p;
            nc.serial_sel = 6'(s << (3 * p));
            setcfg(nc);
            win(SER[16*s+:16]);
         end
      end
      for (s = 0; s < 3; s++) begin
         nc = '0;
         nc.par_en = 1'h1;
         nc.par_sel = 2'(s);
         setcfg(nc);
         win(PAR[16*s+:16]);
      end
      for (s = 0; s < 2; s++) begin
         nc = '0;
         nc.fdc_en = 1'h1;
         nc.fdc_sel = s[0];
         setcfg(nc);
         win(FDC[16*s+:16]);
      end
   endtask
   task automatic t_variable;
      nc = '0;
      nc.acpi_en = 1'h1;
      nc.acpi_base = 16'h4000;
      nc.smb_en = 1'h1;
      nc.smb_base = 16'h5000;
      nc.tco_en = 1'h1;
      nc.tco_base = 16'h5020;
      nc.gen_en = 4'h1;
      nc.gen_base[15:0] = 16'h6000;
      nc.gen_mask[7:0] = 8'h0F;
      setcfg(nc);
      hit(1'h0, 16'h4000, IODEC_TGT_PM, 4'h0, 1'h0);
      hit(1'h1, 16'h405F, IODEC_TGT_PM, 4'h0, 1'h0);
      hit(1'h0, 16'h4060, IODEC_TGT_TERMINATE, 4'h0, 1'h1);
      hit(1'h0, 16'h501F, IODEC_TGT_SMB, 4'h0, 1'h0);
      hit(1'h1, 16'h5020, IODEC_TGT_SMB, 4'h0, 1'h0);
      hit(1'h0, 16'h600F, IODEC_TGT_LPC, 4'h0, 1'h0);
      hit(1'h0, 16'h6010, IODEC_TGT_TERMINATE, 4'h0, 1'h1);
   endtask
   task automatic t_reserved;
      nc = '0;
      nc.post_to_pcie = 1'h1;
      setcfg(nc);
      hit(1'h0, 16'h0084, IODEC_TGT_RESERVED, 4'h0, 1'h1);
      hit(1'h1, 16'h0084, IODEC_TGT_PCIE_SIDE, 4'h0, 1'h0);
      hit(1'h0, 16'h0080, IODEC_TGT_PCIE_SIDE, 4'h0, 1'h0);
      hit(1'h0, 16'h0088, IODEC_TGT_RESERVED, 4'h0, 1'h1);
      hit(1'h0, 16'h0089, IODEC_TGT_TERMINATE, 4'h0, 1'h1);
      hit(1'h0, 16'hFFFF, IODEC_TGT_TERMINATE, 4'h0, 1'h1);
      hit(1'h1, 16'h0F00, IODEC_TGT_TERMINATE, 4'h0, 1'h0);
      hit(1'h0, 16'h0F00, IODEC_TGT_TERMINATE, 4'h0, 1'h1);
   endtask
   // Two cycles on consecutive edges, then the result drops
   task automatic t_back;
      host.drive(1'h1, 1'h0, 16'h0061);
      host.drive(1'h1, 1'h1, 16'h0092);
      look(1'h0, 16'h0061, IODEC_TGT_NMI, 4'h0, 1'h0);
      host.drive(1'h0, 1'h0, 16'h0000);
      look(1'h1, 16'h0092, IODEC_TGT_RESET, 4'h0, 1'h0);
      @(posedge clk_sys);
      #1;
      chk("valid_after", 32'h0, route_q.valid);
   endtask
   // Port 1 window covers fixed space on purpose; ports 5 and 12 overlap
   task automatic t_root;
      logic [191:0] b;
      logic [191:0] l;
      b = '0;
      l = '0;
      l[15:0] = 16'h1FFF;
      b[64+:16] = 16'h2800;
      l[64+:16] = 16'h28FF;
      b[176+:16] = 16'h2000;
      l[176+:16] = 16'h2FFF;
      @(posedge clk_sys);
      rp_en <= 12'h811;
      rp_base <= b;
      rp_limit <= l;
      hit(1'h0, 16'h0061, IODEC_TGT_NMI, 4'h0, 1'h0);
      hit(1'h1, 16'h1FFF, IODEC_TGT_ROOT_PORT, 4'h0, 1'h0);
      hit(1'h0, 16'h2800, IODEC_TGT_ROOT_PORT, 4'h4, 1'h0);
      hit(1'h0, 16'h2FFF, IODEC_TGT_ROOT_PORT, 4'hB, 1'h0);
      hit(1'h1, 16'h3000, IODEC_TGT_TERMINATE, 4'h0, 1'h0);
   endtask
   // A cycle offered while reset is high must not appear
   task automatic t_reset;
      @(posedge clk_sys);
      reset <= 1'h1;
      host.drive(1'h1, 1'h0, 16'h0061);
      host.drive(1'h0, 1'h0, 16'h0000);
      #1;
      chk("route_in_reset", 32'h0, route_q);
      @(posedge clk_sys);
      reset <= 1'h0;
      hit(1'h0, 16'h0061, IODEC_TGT_NMI, 4'h0, 1'h0);
   endtask

   // Main sequence
   initial begin
      clk_sys = 1'h0;
      reset = 1'h1;
      cfg = '0;
      rp_en = '0;
      rp_base = '0;
      rp_limit = '0;
      repeat (10) @(posedge clk_sys);
      reset <= 1'h0;
      #1;
      chk("route_after_reset", 32'h0, route_q);
      t_nmi();
      t_windows();
      t_variable();
      t_reserved();
      t_back();
      t_root();
      t_reset();
      complete_run();
   end
endmodule // test_io_space_address_decoder
